// >>> pkg/adc_regs_defines.svh
// register map, field layout and bus constants for the converter target
`ifndef ADC_REGS_DEFINES_SVH
`define ADC_REGS_DEFINES_SVH
`define SEL_RESULT 2'h0
`define SEL_SETUP 2'h1
`define SEL_LOWER 2'h2
`define SEL_UPPER 2'h3
`define RESULT_RESET 16'h0000
`define SETUP_RESET 16'h8583
`define LOWER_RESET 16'h8000
`define UPPER_RESET 16'h7FFF
`define CODE_POS_FS 16'h7FFF
`define CODE_NEG_FS 16'h8000
`define ADDR_BASE 5'h12
`define GCALL_ADDR 7'h00
`define GCALL_RESET 8'h06
`define STRAP_GND 2'h0
`define STRAP_VDD 2'h1
`define STRAP_SDA 2'h2
`define STRAP_SCL 2'h3
`define F_START 15
`define F_INSEL_HI 14
`define F_INSEL_LO 12
`define F_GAIN_HI 11
`define F_GAIN_LO 9
`define F_MODE 8
`define F_RATE_HI 7
`define F_RATE_LO 5
`define F_CMODE 4
`define F_CPOL 3
`define F_CLAT 2
`define F_QUE_HI 1
`define F_QUE_LO 0
`define BIT_LAST 3'h7
`endif

// >>> pkg/adc_types_pkg.sv
// types shared by the converter target logic
package adc_types_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_RECV = 3'b011,
        ST_SEND = 3'b100,
        ST_MACK = 3'b101,
        ST_SKIP = 3'b110
    } phase_t;
    // which byte of a write transaction is being received
    typedef enum logic [1:0] {
        WB_PTR = 2'b00,
        WB_MSB = 2'b01,
        WB_LSB = 2'b10,
        WB_GC = 2'b11
    } wbyte_t;
endpackage

// >>> verilog/adc_target.sv
// i2c target with pointer-selected 16-bit registers of a converter
`timescale 1ns/10ps
`include "adc_regs_defines.svh"

// Overview of operation
// - after an acknowledged write address, the next byte is the pointer, acknowledged.
// - reads return the register chosen by the last written pointer.
// - pointer persists across transactions until a later pointer write or a general call reset.
// - pointer bits 1:0 select result, setup, lower or upper; bits 7:2 zero.
// - results are two's complement, saturating at 7FFF and 8000.
// - result is read-only, zero after reset until the first conversion.
// - setup word is 16 bits, resets to 8583 with the documented fields.
// - limit registers exist only in the variant with a comparator.
// - two low address bits come from the address-select strap.
// - 16-bit values move as two bytes, msb first, each acknowledged.
// - strap gnd, vdd, sda, scl give addresses 48, 49, 4A, 4B.
// - general call write acked; second byte 06 resets setup, limits and pointer, keeps result, powers down.
module adc_target #(
    parameter int HAS_COMPARATOR = 1,
    parameter int CONV_WIDTH = 17
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_strap,
    input wire logic conv_done,
    input wire logic signed [CONV_WIDTH-1:0] conv_value,
    input wire logic conv_busy,
    output logic start_single,
    output logic power_down,
    output logic [15:0] setup_out,
    output logic [15:0] lower_out,
    output logic [15:0] upper_out
);
    initial begin
        if (CONV_WIDTH < 16 || CONV_WIDTH > 31 || HAS_COMPARATOR < 0 || HAS_COMPARATOR > 1) begin
            $error("adc_target: unsupported parameter values");
        end
    end

    // strap decode, used for address match
    function automatic logic [6:0] own_address(input logic [1:0] strap);
        return {`ADDR_BASE, strap};
    endfunction

    function automatic logic [15:0] saturate(input logic signed [CONV_WIDTH-1:0] v);
        logic signed [CONV_WIDTH-1:0] hi;
        logic signed [CONV_WIDTH-1:0] lo;
        hi = CONV_WIDTH'(signed'({1'b0, `CODE_POS_FS}));
        lo = CONV_WIDTH'(signed'({1'b1, `CODE_NEG_FS}));
        if (v >= hi) begin
            return `CODE_POS_FS;
        end
        if (v <= lo) begin
            return `CODE_NEG_FS;
        end
        return v[15:0];
    endfunction

    // line edge detection
    logic scl_d_reg, scl_d_next, sda_d_reg, sda_d_next;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    assign scl_rise = scl & ~scl_d_reg;
    assign scl_fall = ~scl & scl_d_reg;
    assign start_seen = scl & scl_d_reg & sda_d_reg & ~sda_in;
    assign stop_seen = scl & scl_d_reg & ~sda_d_reg & sda_in;

    adc_types_pkg::phase_t phase_reg, phase_next;
    adc_types_pkg::wbyte_t wbyte_reg, wbyte_next;
    logic [2:0] bitcnt_reg, bitcnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] msb_hold_reg, msb_hold_next;
    logic reading_reg, reading_next;
    logic gcall_reg, gcall_next;
    logic ack_drive_reg, ack_drive_next;
    logic [1:0] ptr_reg, ptr_next;
    logic second_reg, second_next;
    logic [15:0] result_reg, result_next;
    logic [15:0] setup_reg, setup_next;
    logic [15:0] lower_reg, lower_next;
    logic [15:0] upper_reg, upper_next;
    logic sda_out_reg, sda_out_next, sda_oe_reg, sda_oe_next;
    logic start_reg, start_next, pd_reg, pd_next;
    logic [15:0] read_word;
    logic [7:0] got_byte;

    always_comb begin
        case (ptr_reg)
            `SEL_RESULT: read_word = result_reg;
            `SEL_SETUP: read_word = {~conv_busy, setup_reg[14:0]};
            `SEL_LOWER: read_word = (HAS_COMPARATOR != 0) ? lower_reg : 16'h0000;
            `SEL_UPPER: read_word = (HAS_COMPARATOR != 0) ? upper_reg : 16'h0000;
            default: read_word = 16'h0000;
        endcase
    end

    assign got_byte = {shift_reg[6:0], sda_in};

    always_comb begin
        scl_d_next = scl;
        sda_d_next = sda_in;
        phase_next = phase_reg;
        wbyte_next = wbyte_reg;
        bitcnt_next = bitcnt_reg;
        shift_next = shift_reg;
        msb_hold_next = msb_hold_reg;
        reading_next = reading_reg;
        gcall_next = gcall_reg;
        ack_drive_next = ack_drive_reg;
        ptr_next = ptr_reg;
        second_next = second_reg;
        result_next = result_reg;
        setup_next = setup_reg;
        lower_next = lower_reg;
        upper_next = upper_reg;
        sda_out_next = sda_out_reg;
        sda_oe_next = sda_oe_reg;
        start_next = 1'b0;
        pd_next = pd_reg;
        if (conv_done) begin
            result_next = saturate(conv_value);
        end
        if (start_seen) begin
            phase_next = adc_types_pkg::ST_ADDR;
            bitcnt_next = 3'h0;
            ack_drive_next = 1'b0;
            sda_oe_next = 1'b0;
        end else if (stop_seen) begin
            phase_next = adc_types_pkg::ST_IDLE;
            sda_oe_next = 1'b0;
        end else begin
            case (phase_reg)
                adc_types_pkg::ST_ADDR, adc_types_pkg::ST_RECV: begin
                    if (scl_rise) begin
                        shift_next = got_byte;
                        bitcnt_next = bitcnt_reg + 3'h1;
                        if (bitcnt_reg == `BIT_LAST) begin
                            ack_drive_next = 1'b1;
                            if (phase_reg == adc_types_pkg::ST_ADDR) begin
                                reading_next = got_byte[0];
                                gcall_next = 1'b0;
                                wbyte_next = adc_types_pkg::WB_PTR;
                                if (got_byte[7:1] == `GCALL_ADDR && !got_byte[0]) begin
                                    gcall_next = 1'b1;
                                    wbyte_next = adc_types_pkg::WB_GC;
                                end else if (got_byte[7:1] != own_address(addr_strap)) begin
                                    ack_drive_next = 1'b0;
                                    phase_next = adc_types_pkg::ST_SKIP;
                                end
                            end else begin
                                case (wbyte_reg)
                                    adc_types_pkg::WB_PTR: begin
                                        ptr_next = got_byte[1:0];
                                        wbyte_next = adc_types_pkg::WB_MSB;
                                    end
                                    adc_types_pkg::WB_MSB: begin
                                        msb_hold_next = got_byte;
                                        wbyte_next = adc_types_pkg::WB_LSB;
                                    end
                                    adc_types_pkg::WB_LSB: begin
                                        // commit on the eighth bit of the second byte, before its acknowledge
                                        case (ptr_reg)
                                            `SEL_SETUP: begin
                                                setup_next = {1'b1, msb_hold_reg[6:0], got_byte};
                                                start_next = msb_hold_reg[7] & pd_reg;
                                                pd_next = ~msb_hold_reg[0] ? 1'b0 : pd_reg;
                                            end
                                            `SEL_LOWER: begin
                                                if (HAS_COMPARATOR != 0) begin
                                                    lower_next = {msb_hold_reg, got_byte};
                                                end
                                            end
                                            `SEL_UPPER: begin
                                                if (HAS_COMPARATOR != 0) begin
                                                    upper_next = {msb_hold_reg, got_byte};
                                                end
                                            end
                                            default: begin
                                            end
                                        endcase
                                        wbyte_next = adc_types_pkg::WB_MSB;
                                    end
                                    default: begin
                                        if (got_byte == `GCALL_RESET) begin
                                            setup_next = `SETUP_RESET;
                                            lower_next = `LOWER_RESET;
                                            upper_next = `UPPER_RESET;
                                            ptr_next = `SEL_RESULT;
                                            pd_next = 1'b1;
                                        end
                                    end
                                endcase
                            end
                        end
                    end else if (scl_fall && bitcnt_reg == 3'h0) begin
                        if (ack_drive_reg) begin
                            phase_next = adc_types_pkg::ST_ACK;
                            sda_out_next = 1'b0;
                            sda_oe_next = 1'b1;
                        end
                    end
                end
                adc_types_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        ack_drive_next = 1'b0;
                        if (reading_reg && !gcall_reg) begin
                            phase_next = adc_types_pkg::ST_SEND;
                            shift_next = read_word[15:8];
                            msb_hold_next = read_word[7:0];
                            second_next = 1'b0;
                            sda_out_next = read_word[15];
                            sda_oe_next = ~read_word[15];
                            bitcnt_next = 3'h1;
                        end else begin
                            phase_next = adc_types_pkg::ST_RECV;
                            sda_oe_next = 1'b0;
                        end
                    end
                end
                adc_types_pkg::ST_SEND: begin
                    if (scl_fall) begin
                        bitcnt_next = bitcnt_reg + 3'h1;
                        if (bitcnt_reg == 3'h0) begin
                            phase_next = adc_types_pkg::ST_MACK;
                            sda_oe_next = 1'b0;
                        end else begin
                            sda_out_next = shift_reg[`BIT_LAST - bitcnt_reg];
                            sda_oe_next = ~shift_reg[`BIT_LAST - bitcnt_reg];
                        end
                    end
                end
                adc_types_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        ack_drive_next = ~sda_in;
                    end else if (scl_fall) begin
                        if (ack_drive_reg) begin
                            phase_next = adc_types_pkg::ST_SEND;
                            shift_next = second_reg ? shift_reg : msb_hold_reg;
                            second_next = ~second_reg;
                            sda_out_next = second_reg ? shift_reg[7] : msb_hold_reg[7];
                            sda_oe_next = second_reg ? ~shift_reg[7] : ~msb_hold_reg[7];
                            bitcnt_next = 3'h1;
                        end else begin
                            phase_next = adc_types_pkg::ST_SKIP;
                        end
                        ack_drive_next = 1'b0;
                    end
                end
                adc_types_pkg::ST_SKIP: begin
                    sda_oe_next = 1'b0;
                end
                default: begin
                    sda_oe_next = 1'b0;
                end
            endcase
        end
        // single-shot completion wins over a setup write in the same cycle
        if (conv_done && setup_reg[`F_MODE]) begin
            pd_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            phase_reg <= adc_types_pkg::ST_IDLE;
            wbyte_reg <= adc_types_pkg::WB_PTR;
            bitcnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            msb_hold_reg <= 8'h00;
            reading_reg <= 1'b0;
            gcall_reg <= 1'b0;
            ack_drive_reg <= 1'b0;
            ptr_reg <= `SEL_RESULT;
            second_reg <= 1'b0;
            result_reg <= `RESULT_RESET;
            setup_reg <= `SETUP_RESET;
            lower_reg <= `LOWER_RESET;
            upper_reg <= `UPPER_RESET;
            sda_out_reg <= 1'b1;
            sda_oe_reg <= 1'b0;
            start_reg <= 1'b0;
            pd_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
            phase_reg <= phase_next;
            wbyte_reg <= wbyte_next;
            bitcnt_reg <= bitcnt_next;
            shift_reg <= shift_next;
            msb_hold_reg <= msb_hold_next;
            reading_reg <= reading_next;
            gcall_reg <= gcall_next;
            ack_drive_reg <= ack_drive_next;
            ptr_reg <= ptr_next;
            second_reg <= second_next;
            result_reg <= result_next;
            setup_reg <= setup_next;
            lower_reg <= lower_next;
            upper_reg <= upper_next;
            sda_out_reg <= sda_out_next;
            sda_oe_reg <= sda_oe_next;
            start_reg <= start_next;
            pd_reg <= pd_next;
        end
    end

    assign sda_out = sda_out_reg;
    assign sda_oe = sda_oe_reg;
    assign start_single = start_reg;
    assign power_down = pd_reg;
    assign setup_out = setup_reg;
    assign lower_out = lower_reg;
    assign upper_out = upper_reg;

    sequence ptr_written;
        phase_reg == adc_types_pkg::ST_RECV && wbyte_reg == adc_types_pkg::WB_PTR
            && scl_rise && bitcnt_reg == `BIT_LAST && !start_seen && !stop_seen;
    endsequence

    chk_ptr_capture: assert property (@(posedge clk) disable iff (reset)
        ptr_written |=> ptr_reg == $past(got_byte[1:0]))
        else $error("pointer not captured");
    chk_ptr_hold: assert property (@(posedge clk) disable iff (reset)
        (phase_reg != adc_types_pkg::ST_RECV && !$past(reset)) |=> $stable(ptr_reg) || $past(gcall_reg))
        else $error("pointer changed outside a write");
    chk_result_sat: assert property (@(posedge clk) disable iff (reset)
        (conv_done && conv_value > CONV_WIDTH'(32767)) |=> result_reg == `CODE_POS_FS)
        else $error("result did not saturate high");
    chk_result_hold: assert property (@(posedge clk) disable iff (reset)
        !conv_done |=> $stable(result_reg))
        else $error("result changed without conversion");
    chk_nack_release: assert property (@(posedge clk) disable iff (reset)
        phase_reg == adc_types_pkg::ST_SKIP |-> !sda_oe_reg)
        else $error("sda driven after nack");
    chk_upper_commit: assert property (@(posedge clk) disable iff (reset)
        (wbyte_reg != adc_types_pkg::WB_LSB && !$past(gcall_reg)) |=> $stable(upper_reg))
        else $error("limit written before second byte");
    chk_no_comparator: assert property (@(posedge clk) disable iff (reset)
        (HAS_COMPARATOR == 0 && ptr_reg[1]) |-> read_word == 16'h0000)
        else $error("limit storage visible without comparator");
    chk_setup_reset: assert property (@(posedge clk)
        $past(reset) |-> setup_reg == `SETUP_RESET)
        else $error("setup reset value wrong");
endmodule

// >>> testbench/bus_controller_model.sv
// behavioural bus controller that drives the bus clock and data toward the target
`timescale 1ns/10ps
module bus_controller_model #(
    parameter int QUARTER = 6
) (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_low
);
    // bus idles high; a released data line reads as the pull-up level
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // quarter bit of 6 clk gives the target several samples of every bus level
    task automatic wait_q();
        repeat (QUARTER) @(negedge clk);
    endtask

    task automatic bit_out(input logic b);
        sda_low = ~b;
        wait_q();
        scl = 1'b1;
        wait_q();
        wait_q();
        scl = 1'b0;
        wait_q();
    endtask

    task automatic bit_in(output logic b);
        sda_low = 1'b0;
        wait_q();
        scl = 1'b1;
        wait_q();
        b = sda_wire;
        wait_q();
        scl = 1'b0;
        wait_q();
    endtask

    task automatic start();
        sda_low = 1'b0;
        wait_q();
        scl = 1'b1;
        wait_q();
        sda_low = 1'b1;
        wait_q();
        scl = 1'b0;
        wait_q();
    endtask

    task automatic stop();
        sda_low = 1'b1;
        wait_q();
        scl = 1'b1;
        wait_q();
        sda_low = 1'b0;
        wait_q();
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(a);
        ack = ~a;
    endtask

    // last byte of a read is left unacknowledged to end the transfer
    task automatic read_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(last);
    endtask
endmodule

// >>> testbench/adc_i2c_register_access_bench.sv
// self-checking bench for the converter target's register access over the bus
`timescale 1ns/10ps
`include "adc_regs_defines.svh"
module adc_i2c_register_access_bench;
    logic clk, reset, scl, sda_low, sda_wire, sda_out, sda_oe, sda_out2, sda_oe2;
    logic conv_done, conv_busy, start_single, power_down;
    logic [1:0] addr_strap;
    logic signed [16:0] conv_value;
    logic [15:0] setup_out, lower_out, upper_out;
    logic [6:0] dev_addr;
    logic [16:0] raw [5] = '{17'h0FFFF, 17'h10000, 17'h00001, 17'h1FFFF, 17'h07FFF};
    logic [15:0] sat [5] = '{16'h7FFF, 16'h8000, 16'h0001, 16'hFFFF, 16'h7FFF};
    logic [15:0] regs [4] = '{16'h7FFF, 16'h8483, 16'h1234, 16'hABCD};
    int miscompares, cmp_count, cycles, starts;

    assign sda_wire = (sda_low || (sda_oe && !sda_out) || (sda_oe2 && !sda_out2)) ? 1'b0 : 1'b1;

    adc_target adc_target_i (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap), .conv_done(conv_done),
        .conv_value(conv_value), .conv_busy(conv_busy), .start_single(start_single),
        .power_down(power_down), .setup_out(setup_out), .lower_out(lower_out),
        .upper_out(upper_out));

    // variant without limits answers at the sda strap code while the bench uses gnd
    adc_target #(.HAS_COMPARATOR(0)) adc_target_nocmp_i (.clk(clk), .reset(reset),
        .scl(scl), .sda_in(sda_wire), .sda_out(sda_out2), .sda_oe(sda_oe2),
        .addr_strap(addr_strap ^ 2'h2), .conv_done(conv_done), .conv_value(conv_value),
        .conv_busy(conv_busy), .start_single(), .power_down(), .setup_out(),
        .lower_out(), .upper_out());

    bus_controller_model bus_controller_model_i (.clk(clk), .sda_wire(sda_wire), .scl(scl),
        .sda_low(sda_low));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // whole run needs about 20k cycles
    always @(posedge clk) begin
        cycles++;
        if (start_single) starts++;
        if (cycles == 60000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic a;
        bus_controller_model_i.write_byte(d, a);
        check("ack", {15'h0, a}, {15'h0, exp_ack});
    endtask

    // pointer byte always leads, even when unchanged
    task automatic reg_write(input logic [7:0] ptr, input logic [15:0] d, input int nbytes);
        bus_controller_model_i.start();
        send({dev_addr, 1'b0}, 1'b1);
        send(ptr, 1'b1);
        if (nbytes > 0) send(d[15:8], 1'b1);
        if (nbytes > 1) send(d[7:0], 1'b1);
        bus_controller_model_i.stop();
    endtask

    task automatic reg_read(input logic [7:0] ptr, input logic set_ptr, input int nbytes,
                            input logic [15:0] exp, input string what);
        logic [7:0] hi, lo;
        if (set_ptr) reg_write(ptr, 16'h0000, 0);
        bus_controller_model_i.start();
        send({dev_addr, 1'b1}, 1'b1);
        bus_controller_model_i.read_byte(hi, nbytes == 1);
        if (nbytes == 1) begin
            check(what, {8'h00, hi}, {8'h00, exp[15:8]});
        end else begin
            bus_controller_model_i.read_byte(lo, 1'b1);
            check(what, {hi, lo}, exp);
        end
        bus_controller_model_i.stop();
    endtask

    initial begin
        reset = 1'b1;
        addr_strap = `STRAP_GND;
        conv_done = 1'b0;
        conv_busy = 1'b0;
        conv_value = '0;
        dev_addr = {`ADDR_BASE, `STRAP_GND};
        repeat (4) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        check("setup_out", setup_out, `SETUP_RESET);
        reg_read(8'h00, 1'b0, 2, `RESULT_RESET, "result reset");
        for (int i = 0; i < 5; i++) begin
            conv_value = raw[i];
            conv_done = 1'b1;
            @(negedge clk);
            conv_done = 1'b0;
            reg_read(8'h00, 1'b0, 2, sat[i], "result");
        end
        // bit 15 written 0 and bit 8 cleared: status shows idle, leaves power-down
        reg_write(8'h01, 16'h0483, 2);
        check("setup_out", {1'b0, setup_out[14:0]}, 16'h0483);
        check("power_down", {15'h0, power_down}, 16'h0000);
        conv_busy = 1'b1;
        reg_read(8'h01, 1'b1, 2, 16'h0483, "setup busy");
        conv_busy = 1'b0;
        reg_write(8'h02, 16'h1234, 2);
        reg_write(8'h03, 16'hABCD, 2);
        reg_write(8'h02, 16'h5600, 1);
        check("lower_out", lower_out, 16'h1234);
        check("upper_out", upper_out, 16'hABCD);
        for (int p = 0; p < 4; p++) begin
            reg_read(p[7:0], 1'b1, 2, regs[p], "select");
        end
        reg_read(8'h03, 1'b0, 1, 16'hAB00, "upper one byte");
        bus_controller_model_i.start();
        send({`GCALL_ADDR, 1'b0}, 1'b1);
        send(`GCALL_RESET, 1'b1);
        bus_controller_model_i.stop();
        check("setup_out", setup_out, `SETUP_RESET);
        check("lower_out", lower_out, `LOWER_RESET);
        check("power_down", {15'h0, power_down}, 16'h0001);
        reg_read(8'h00, 1'b0, 2, 16'h7FFF, "result kept");
        // powered down after the general call, so a start bit launches one conversion
        reg_write(8'h01, `SETUP_RESET, 2);
        check("start_single", starts[15:0], 16'h0001);
        dev_addr = {`ADDR_BASE, `STRAP_SDA};
        reg_write(8'h03, 16'h1357, 2);
        reg_read(8'h03, 1'b0, 2, 16'h0000, "no comparator limit");
        for (int s = 0; s < 4; s++) begin
            addr_strap = s[1:0];
            dev_addr = {`ADDR_BASE, s[1:0] + 2'h1};
            bus_controller_model_i.start();
            send({dev_addr, 1'b0}, 1'b0);
            bus_controller_model_i.stop();
            dev_addr = {`ADDR_BASE, s[1:0]};
            bus_controller_model_i.start();
            send({dev_addr, 1'b0}, 1'b1);
            bus_controller_model_i.stop();
        end
        complete_run();
    end
endmodule
